// ==== bench/test_uatr_chan.sv ====
// Bench of one serial channel against the far-end model.
// Assumes read data shows one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
`include "uatr_defs.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_uatr_chan;
    logic clock = 1'b0, sys_rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, cts_n = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, rdata_q, got, got_n, d;
    logic [4:0] bt = `UATR_BT_16X;
    logic tx_q, rts_n_q, rx_in, irq, txrdy_n, rxrdy_n;
    int n_fail = 0, total_checks = 0;
    always #12.5 clock = ~clock;
    uatr_chan uut (.clock(clock), .sys_rst(sys_rst), .samp_tick(1'b1), .addr(addr),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .wdata(wdata), .rdata_q(rdata_q),
        .rx_in(rx_in), .cts_n(cts_n), .tx_q(tx_q), .rts_n_q(rts_n_q), .irq_q(irq),
        .txrdy_n_q(txrdy_n), .rxrdy_n_q(rxrdy_n));
    uatr_remote rem (.clock(clock), .bt(bt), .tx_in(tx_q), .cts_n(rts_n_q),
        .rx_out(rx_in), .got(got), .got_n(got_n));
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        addr = a;
        wdata = v;
        wr_stb = 1'b1;
        @(negedge clock);
        wr_stb = 1'b0;
        @(negedge clock);
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        addr = a;
        rd_stb = 1'b1;
        @(negedge clock);
        rd_stb = 1'b0;
        v = rdata_q;
        @(negedge clock);
    endtask
    task automatic wait_tx(input logic [7:0] n);
        for (int i = 0; i < 4000 && got_n == n; i++) @(negedge clock);
    endtask
    task automatic t_rates;
        logic [7:0] n;
        logic [1:0] code [3] = '{`UATR_OS_16X, `UATR_OS_8X, `UATR_OS_4X};
        logic [4:0] bts [3] = '{`UATR_BT_16X, `UATR_BT_8X, `UATR_BT_4X};
        for (int k = 0; k < 3; k++) begin
            wr(`UATR_A_DFRAC, {2'b00, code[k], 4'h0});
            bt = bts[k];
            n = got_n;
            wr(`UATR_A_DATA, 8'hA5);
            wr(`UATR_A_DATA, 8'h3C);
            wait_tx(n);
            `CHK(got, 8'hA5)
            wait_tx(n + 8'h01);
            `CHK(got, 8'h3C)
            repeat (2 * bt) @(negedge clock);
            rd(`UATR_A_LSTAT, d);
            `CHK(d[6:5], 2'b11)
            `CHK(txrdy_n, 1'b0)
            rem.send(8'hC3);
            rd(`UATR_A_LSTAT, d);
            `CHK(d[4:0], 5'h01)
            rd(`UATR_A_DATA, d);
            `CHK(d, 8'hC3)
        end
        wr(`UATR_A_DFRAC, 8'h00);
        bt = `UATR_BT_16X;
    endtask
    task automatic t_cts;
        logic [7:0] n;
        wr(`UATR_A_EFEAT, 8'h80);
        cts_n = 1'b1;
        n = got_n;
        wr(`UATR_A_DATA, 8'h5A);
        repeat (400) @(negedge clock);
        `CHK(got_n, n)
        cts_n = 1'b0;
        wait_tx(n);
        `CHK(got, 8'h5A)
    endtask
    task automatic t_rts;
        wr(`UATR_A_EFEAT, 8'h50);
        wr(`UATR_A_IEN, 8'h40);
        wr(`UATR_A_MCTL, 8'h02);
        @(negedge clock);
        `CHK(rts_n_q, 1'b0)
        for (int i = 0; i < 16; i++) rem.send(8'(i));
        repeat (4) @(negedge clock);
        `CHK(rts_n_q, 1'b1)
        `CHK(irq, 1'b1)
        `CHK(rxrdy_n, 1'b0)
        rd(`UATR_A_ISTAT, d);
        `CHK(d, 8'h20)
        for (int i = 0; i < 16; i++) begin
            `CHK(rts_n_q, 1'b1)
            rd(`UATR_A_DATA, d);
            `CHK(d, 8'(i))
        end
        @(negedge clock);
        `CHK(rts_n_q, 1'b0)
        `CHK(irq, 1'b0)
    endtask
    task automatic test_done;
        if (n_fail == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clock);
        sys_rst = 1'b0;
        @(negedge clock);
        wr(`UATR_A_LCTL, 8'h03);
        wr(`UATR_A_ISTAT, 8'h01);
        wr(`UATR_A_MCTL, 8'h02);
        t_rates;
        t_cts;
        t_rts;
        test_done;
    end
    // Cuts a hang short
    initial begin
        #1500000;
        n_fail++;
        test_done;
    end
endmodule
`default_nettype wire

// ==== bench/uatr_remote.sv ====
// Far serial end: sends bytes on request, captures what arrives.
// Assumes bt clock cycles per bit and lines idling high.
`timescale 1ns/1ps
`default_nettype none
module uatr_remote (
    // Clock and bit time
    input wire logic clock,
    input wire logic [4:0] bt,
    // Serial lines
    input wire logic tx_in,
    input wire logic cts_n,
    output logic rx_out,
    // Capture
    output logic [7:0] got,
    output logic [7:0] got_n
);
    initial begin
        rx_out = 1'b1;
        got = 8'h00;
        got_n = 8'h00;
    end
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        while (cts_n !== 1'b0) @(negedge clock);
        for (int i = 0; i < 10; i++) begin
            rx_out = f[i];
            repeat (bt) @(negedge clock);
        end
    endtask
    // Samples each bit at its centre
    always begin
        @(negedge tx_in);
        repeat (bt / 2) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            repeat (bt) @(posedge clock);
            got[i] = tx_in;
        end
        repeat (bt) @(posedge clock);
        got_n = got_n + 8'h01;
    end
endmodule
`default_nettype wire

// ==== hdl/uatr_chan.sv ====
// One serial channel: FIFO and the transmit/receive/flow control logic.
// Assumes samp_tick pulses once per oversampling clock, all inputs synchronous.
`timescale 1ns/1ps
`default_nettype none
`include "uatr_defs.svh"

module uatr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic flush,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;
    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rp_q];
    assign count = cnt_q;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end
    always_ff @(posedge clock) begin
        if (sys_rst || flush) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            wp_q <= wp_q + AW'(push);
            rp_q <= rp_q + AW'(pop);
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module uatr_chan (
    // Clock, reset, sampling tick
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic samp_tick,
    // Host register port
    input wire logic [2:0] addr,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata_q,
    // Serial link
    input wire logic rx_in,
    input wire logic cts_n,
    output logic tx_q,
    output logic rts_n_q,
    // Status pins
    output logic irq_q,
    output logic txrdy_n_q,
    output logic rxrdy_n_q
);
    logic [7:0] ien_q, fctl_q, lctl_q, mctl_q, efeat_q, dfrac_q;
    logic ovr_q, tmo_q, flow_q, cts_prev_q, rts_off_q;
    uatr_pkg::uatr_st_e tx_st_q, rx_st_q;
    logic [7:0] tx_sh_q, rx_sh_q;
    logic [4:0] tx_cnt_q, rx_cnt_q;
    logic [2:0] tx_idx_q, rx_idx_q;
    logic tx_stop2_q, rx_perr_q, tx_par_q;
    logic [10:0] tmo_cnt_q;
    logic fifo_en, wr_thr, rd_rhr, flush_tx, flush_rx;
    logic [4:0] bit_t, half_t;
    logic [2:0] wl_last;
    logic tx_tick_end, rx_half, rx_end;
    logic txf_ready, txf_valid, txf_pop, rxf_ready, rxf_valid, rxf_push;
    logic [7:0] txf_data;
    logic [10:0] rxf_data, rxf_in;
    logic [6:0] txf_cnt, rxf_cnt, rx_trig, rts_hi, rts_lo;
    logic tx_ok, thr_empty, tx_empty, rx_rdy_int, tx_line, auto_rts;
    logic [7:0] lstat, istat, rd_mux;
    logic [10:0] tmo_lim;

    assign fifo_en = fctl_q[0];
    assign wr_thr = wr_stb && (addr == `UATR_A_DATA);
    assign rd_rhr = rd_stb && (addr == `UATR_A_DATA);
    assign flush_tx = wr_stb && (addr == `UATR_A_ISTAT) && wdata[2];
    assign flush_rx = wr_stb && (addr == `UATR_A_ISTAT) && wdata[1];
    assign wl_last = 3'(lctl_q[1:0]) + 3'h4;

    always_comb begin
        unique case (dfrac_q[5:4])
            `UATR_OS_8X: bit_t = `UATR_BT_8X;
            `UATR_OS_4X: bit_t = `UATR_BT_4X;
            default: bit_t = `UATR_BT_16X;
        endcase
        half_t = bit_t >> 1;
    end

    // Host register writes
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ien_q <= `UATR_REG_RST;
            fctl_q <= `UATR_REG_RST;
            lctl_q <= `UATR_REG_RST;
            mctl_q <= `UATR_REG_RST;
            efeat_q <= `UATR_REG_RST;
            dfrac_q <= `UATR_REG_RST;
        end else if (wr_stb) begin
            unique case (addr)
                `UATR_A_IEN: ien_q <= efeat_q[4] ? wdata : {4'h0, wdata[3:0]};
                `UATR_A_ISTAT: fctl_q <= wdata;
                `UATR_A_LCTL: lctl_q <= wdata;
                `UATR_A_MCTL: mctl_q <= wdata;
                `UATR_A_EFEAT: efeat_q <= wdata;
                `UATR_A_DFRAC: dfrac_q <= wdata;
                default: ;
            endcase
        end
    end

    // Host writes go into the transmit FIFO
    uatr_fifo #(.WIDTH(8), .DEPTH(`UATR_FIFO_DEPTH)) u_txf (
        .clock(clock),
        .sys_rst(sys_rst),
        .flush(flush_tx),
        .in_valid(wr_thr),
        .in_ready(txf_ready),
        .in_data(wdata),
        .out_valid(txf_valid),
        .out_ready(txf_pop),
        .out_data(txf_data),
        .count(txf_cnt)
    );

    uatr_fifo #(.WIDTH(`UATR_RX_W), .DEPTH(`UATR_FIFO_DEPTH)) u_rxf (
        .clock(clock),
        .sys_rst(sys_rst),
        .flush(flush_rx),
        .in_valid(rxf_push),
        .in_ready(rxf_ready),
        .in_data(rxf_in),
        .out_valid(rxf_valid),
        .out_ready(rd_rhr),
        .out_data(rxf_data),
        .count(rxf_cnt)
    );

    // Auto CTS gates only the start of a new character
    assign tx_ok = !(efeat_q[7] && cts_n);
    assign txf_pop = (tx_st_q == uatr_pkg::UATR_IDLE) && tx_ok;
    assign tx_tick_end = samp_tick && (tx_cnt_q == bit_t - 5'h1);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_st_q <= uatr_pkg::UATR_IDLE;
            tx_sh_q <= 8'h00;
            tx_cnt_q <= 5'h00;
            tx_idx_q <= 3'h0;
            tx_stop2_q <= 1'b0;
        end else begin
            tx_cnt_q <= tx_tick_end ? 5'h00 : tx_cnt_q + 5'(samp_tick);
            unique case (tx_st_q)
                uatr_pkg::UATR_IDLE: begin
                    tx_cnt_q <= 5'h00;
                    if (txf_pop && txf_valid) begin
                        tx_sh_q <= txf_data;
                        tx_st_q <= uatr_pkg::UATR_START;
                    end
                end
                uatr_pkg::UATR_START: if (tx_tick_end) begin
                    tx_idx_q <= 3'h0;
                    tx_st_q <= uatr_pkg::UATR_DATA;
                end
                uatr_pkg::UATR_DATA: if (tx_tick_end) begin
                    tx_sh_q <= tx_sh_q >> 1;
                    tx_idx_q <= tx_idx_q + 3'h1;
                    if (tx_idx_q == wl_last) begin
                        tx_stop2_q <= lctl_q[2];
                        tx_st_q <= lctl_q[3] ? uatr_pkg::UATR_PAR : uatr_pkg::UATR_STOP;
                    end
                end
                uatr_pkg::UATR_PAR: if (tx_tick_end) begin
                    tx_st_q <= uatr_pkg::UATR_STOP;
                end
                uatr_pkg::UATR_STOP: if (tx_tick_end) begin
                    tx_stop2_q <= 1'b0;
                    if (!tx_stop2_q) begin
                        tx_st_q <= uatr_pkg::UATR_IDLE;
                    end
                end
            endcase
        end
    end

    // Running parity of the bits sent so far
    always_ff @(posedge clock) begin
        if (sys_rst || tx_st_q == uatr_pkg::UATR_START) begin
            tx_par_q <= 1'b0;
        end else if (tx_st_q == uatr_pkg::UATR_DATA && tx_tick_end) begin
            tx_par_q <= tx_par_q ^ tx_sh_q[0];
        end
    end

    always_comb begin
        unique case (tx_st_q)
            uatr_pkg::UATR_START: tx_line = 1'b0;
            uatr_pkg::UATR_DATA: tx_line = tx_sh_q[0];
            uatr_pkg::UATR_PAR: tx_line = tx_par_q ^ !lctl_q[4];
            default: tx_line = 1'b1;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_q <= 1'b1;
        end else begin
            tx_q <= tx_line;
        end
    end

    // Holding empty once the byte left for the shifter
    assign thr_empty = !txf_valid;
    assign tx_empty = thr_empty && (tx_st_q == uatr_pkg::UATR_IDLE);

    assign rx_half = samp_tick && (rx_cnt_q == half_t - 5'h1);
    assign rx_end = samp_tick && (rx_cnt_q == bit_t - 5'h1);
    logic rxf_room, rx_stop_ok, rx_brk, rts_off_d, rts_n_d;
    logic [7:0] rx_byte;

    // Transmit checks
    a_tx_load_byte: assert property (@(posedge clock) disable iff (sys_rst)
        (tx_st_q == uatr_pkg::UATR_IDLE && txf_pop && txf_valid) |=> (tx_st_q == uatr_pkg::UATR_START && tx_sh_q == $past(txf_data)))
        else $error("transmit shifter missed the FIFO head");
    a_cts_holds: assert property (@(posedge clock) disable iff (sys_rst)
        (tx_st_q == uatr_pkg::UATR_IDLE && efeat_q[7] && cts_n) |=> (tx_st_q == uatr_pkg::UATR_IDLE))
        else $error("transmit started while the far end held us off");
    a_tx_empty_idle: assert property (@(posedge clock) disable iff (sys_rst)
        lstat[6] |-> (tx_st_q == uatr_pkg::UATR_IDLE && txf_cnt == `UATR_LVL_0))
        else $error("transmit empty shown while data remains");

    // Accept while room remains, one entry in non-FIFO mode
    assign rxf_room = fifo_en ? rxf_ready : (rxf_cnt == `UATR_LVL_0);
    assign rx_stop_ok = (rx_st_q == uatr_pkg::UATR_STOP) && rx_end;
    assign rxf_push = rx_stop_ok && rxf_room;
    assign rx_byte = rx_sh_q >> (3'h7 - wl_last);
    assign rx_brk = !rx_in && (rx_byte == 8'h00);
    assign rxf_in = {rx_brk, !rx_in, lctl_q[3] && rx_perr_q, rx_byte};

    // Receive sequencer, start check then centre samples
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rx_st_q <= uatr_pkg::UATR_IDLE;
            rx_sh_q <= 8'h00;
            rx_cnt_q <= 5'h00;
            rx_idx_q <= 3'h0;
        end else begin
            rx_cnt_q <= rx_end ? 5'h00 : rx_cnt_q + 5'(samp_tick);
            unique case (rx_st_q)
                uatr_pkg::UATR_IDLE: begin
                    rx_cnt_q <= 5'h00;
                    if (!rx_in) begin
                        rx_st_q <= uatr_pkg::UATR_START;
                    end
                end
                uatr_pkg::UATR_START: if (rx_half) begin
                    rx_cnt_q <= 5'h00;
                    rx_idx_q <= 3'h0;
                    rx_st_q <= rx_in ? uatr_pkg::UATR_IDLE : uatr_pkg::UATR_DATA;
                end
                uatr_pkg::UATR_DATA: if (rx_end) begin
                    rx_sh_q <= {rx_in, rx_sh_q[7:1]};
                    rx_idx_q <= rx_idx_q + 3'h1;
                    if (rx_idx_q == wl_last) begin
                        rx_st_q <= lctl_q[3] ? uatr_pkg::UATR_PAR : uatr_pkg::UATR_STOP;
                    end
                end
                uatr_pkg::UATR_PAR: if (rx_end) begin
                    rx_st_q <= uatr_pkg::UATR_STOP;
                end
                uatr_pkg::UATR_STOP: if (rx_end) begin
                    rx_st_q <= uatr_pkg::UATR_IDLE;
                end
            endcase
        end
    end
    a_start_reject: assert property (@(posedge clock) disable iff (sys_rst)
        (rx_st_q == uatr_pkg::UATR_START && rx_half && rx_in) |=> (rx_st_q == uatr_pkg::UATR_IDLE))
        else $error("false start bit was accepted");

    // Parity check of received bits
    always_ff @(posedge clock) begin
        if (sys_rst || rx_st_q == uatr_pkg::UATR_START) begin
            rx_perr_q <= 1'b0;
        end else if (rx_st_q == uatr_pkg::UATR_DATA && rx_end) begin
            rx_perr_q <= rx_perr_q ^ rx_in;
        end else if (rx_st_q == uatr_pkg::UATR_PAR && rx_end) begin
            rx_perr_q <= rx_perr_q ^ rx_in ^ !lctl_q[4];
        end
    end

    // Trigger level and its hysteresis pair
    always_comb begin
        unique case (fctl_q[7:6])
            2'h0: {rx_trig, rts_hi, rts_lo} = {`UATR_LVL_8, `UATR_LVL_16, `UATR_LVL_0};
            2'h1: {rx_trig, rts_hi, rts_lo} = {`UATR_LVL_16, `UATR_LVL_56, `UATR_LVL_8};
            2'h2: {rx_trig, rts_hi, rts_lo} = {`UATR_LVL_56, `UATR_LVL_60, `UATR_LVL_16};
            2'h3: {rx_trig, rts_hi, rts_lo} = {`UATR_LVL_60, `UATR_LVL_60, `UATR_LVL_56};
        endcase
    end

    // Auto RTS needs both the enable and the software request
    assign auto_rts = efeat_q[6] && mctl_q[1];
    // Off at the upper level, back on at the lower
    assign rts_off_d = auto_rts && (rxf_cnt >= rts_hi || (rts_off_q && rxf_cnt > rts_lo));
    assign rts_n_d = !mctl_q[1] || rts_off_d;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rts_off_q <= 1'b0;
            rts_n_q <= 1'b1;
        end else begin
            rts_off_q <= rts_off_d;
            rts_n_q <= rts_n_d;
        end
    end
    a_rts_off_high: assert property (@(posedge clock) disable iff (sys_rst)
        (auto_rts && rxf_cnt >= rts_hi) |=> rts_n_q)
        else $error("request to send still on above upper level");
    a_rts_on_low: assert property (@(posedge clock) disable iff (sys_rst)
        (auto_rts && rxf_cnt <= rts_lo) |=> !rts_n_q)
        else $error("request to send still off below lower level");

    // Time-out counter, idle while the FIFO is empty
    assign tmo_lim = 11'((`UATR_TMO_WORDS * (5 + lctl_q[1:0]) + `UATR_TMO_EXTRA) * bit_t);
    always_ff @(posedge clock) begin
        if (sys_rst || !rxf_valid || rxf_push || rd_rhr) begin
            tmo_cnt_q <= 11'h000;
            tmo_q <= 1'b0;
        end else if (tmo_cnt_q != tmo_lim) begin
            tmo_cnt_q <= tmo_cnt_q + 11'(samp_tick);
        end else begin
            tmo_q <= 1'b1;
        end
    end

    // Flow and overrun flags, new event wins over clearing read
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cts_prev_q <= 1'b1;
            flow_q <= 1'b0;
            ovr_q <= 1'b0;
        end else begin
            cts_prev_q <= cts_n;
            if ((ien_q[6] && rts_n_d && !rts_n_q) || (ien_q[7] && cts_n && !cts_prev_q)) begin
                flow_q <= 1'b1;
            end else if (rd_stb && addr == `UATR_A_ISTAT) begin
                flow_q <= 1'b0;
            end
            if (rx_stop_ok && !rxf_room) begin
                ovr_q <= 1'b1;
            end else if (rd_stb && addr == `UATR_A_LSTAT) begin
                ovr_q <= 1'b0;
            end
        end
    end

    assign rx_rdy_int = fifo_en ? (rxf_cnt >= rx_trig) : rxf_valid;
    // Tags follow the head of the receive FIFO
    assign lstat = {1'b0, tx_empty, thr_empty, rxf_valid ? rxf_data[10:8] : 3'h0, ovr_q, rxf_valid};
    assign istat = (ien_q[0] && tmo_q) ? `UATR_ISR_TMO :
        (ien_q[0] && rx_rdy_int) ? `UATR_ISR_RXRDY :
        (ien_q[1] && thr_empty) ? `UATR_ISR_THR :
        flow_q ? `UATR_ISR_FLOW : `UATR_ISR_NONE;

    always_comb begin
        unique case (addr)
            `UATR_A_DATA: rd_mux = rxf_data[7:0];
            `UATR_A_IEN: rd_mux = ien_q;
            `UATR_A_ISTAT: rd_mux = istat;
            `UATR_A_LCTL: rd_mux = lctl_q;
            `UATR_A_MCTL: rd_mux = mctl_q;
            `UATR_A_LSTAT: rd_mux = lstat;
            `UATR_A_EFEAT: rd_mux = efeat_q;
            `UATR_A_DFRAC: rd_mux = dfrac_q;
        endcase
    end

    // Outputs leave from flip-flops
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdata_q <= `UATR_REG_RST;
            irq_q <= 1'b0;
            txrdy_n_q <= 1'b0;
            rxrdy_n_q <= 1'b1;
        end else begin
            if (rd_stb) begin
                rdata_q <= rd_mux;
            end
            irq_q <= (istat != `UATR_ISR_NONE);
            txrdy_n_q <= fifo_en ? !txf_ready : !thr_empty;
            rxrdy_n_q <= !(rx_rdy_int || tmo_q);
        end
    end
endmodule
`default_nettype wire

// ==== shared/uatr_defs.svh ====
// Constants of one serial channel: register offsets, fields, levels, timing.
// Assumes a parallel host port with a 3-bit address and one sampling tick input.
// Function
// - Shifter sends one bit per bit time
// - Fraction field selects 16X, 8X or 4X
// - Frame: start, data, optional parity, stop
// - Data leaves least significant bit first
// - FIFO mode: holding writes push transmit FIFO
// - Non-FIFO: holding empty set on shifter load
// - FIFO mode: holding empty while FIFO empty
// - Holding empty raises enabled transmit interrupt
// - Transmit empty only when shifter idle
// - Start bit confirmed low at half bit
// - Data and stop sampled at bit centre
// - Receive FIFO 64 by 11 with tags
// - Holding read pops and updates tags
// - Receive ready per character or trigger
// - Time-out after four words plus twelve
// - Auto RTS enabled, started by modem bit
// - RTS rising sets enabled flow interrupt
// - RTS off at next higher level; at trigger 60 the code turns RTS off at 60 itself
// - RTS on at next lower level
// - Receiver keeps filling until FIFO full
// - High CTS halts after current stop bit
// - CTS rising sets enabled flow interrupt
`ifndef UATR_DEFS_SVH
`define UATR_DEFS_SVH
`define UATR_A_DATA 3'h0
`define UATR_A_IEN 3'h1
`define UATR_A_ISTAT 3'h2
`define UATR_A_LCTL 3'h3
`define UATR_A_MCTL 3'h4
`define UATR_A_LSTAT 3'h5
`define UATR_A_EFEAT 3'h6
`define UATR_A_DFRAC 3'h7
`define UATR_FIFO_DEPTH 64
`define UATR_CNT_W 7
`define UATR_RX_W 11
`define UATR_OS_16X 2'h0
`define UATR_OS_8X 2'h1
`define UATR_OS_4X 2'h2
`define UATR_BT_16X 5'h10
`define UATR_BT_8X 5'h08
`define UATR_BT_4X 5'h04
`define UATR_LVL_0 7'h00
`define UATR_LVL_8 7'h08
`define UATR_LVL_16 7'h10
`define UATR_LVL_56 7'h38
`define UATR_LVL_60 7'h3C
`define UATR_LVL_64 7'h40
`define UATR_TMO_WORDS 4
`define UATR_TMO_EXTRA 12
`define UATR_ISR_NONE 8'h01
`define UATR_ISR_THR 8'h02
`define UATR_ISR_RXRDY 8'h04
`define UATR_ISR_TMO 8'h0C
`define UATR_ISR_FLOW 8'h20
`define UATR_REG_RST 8'h00
`endif

// ==== shared/uatr_pkg.sv ====
// Types of the serial channel.
// Assumes uatr_defs.svh supplies the numeric constants.
package uatr_pkg;
    typedef enum logic [4:0] {
        UATR_IDLE = 5'h01,
        UATR_START = 5'h02,
        UATR_DATA = 5'h04,
        UATR_PAR = 5'h08,
        UATR_STOP = 5'h10
    } uatr_st_e;
    typedef logic [7:0] uatr_byte_t;
endpackage
